// File: src/crxb_rx_select.sv
// CAN receive buffer search, priority selection, storage and history.
// Assumes frames arrive as a one-cycle valid pulse from the protocol engine
// and buffer configuration is supplied as flat vectors from the CPU side.
//
// Behaviour
// [RULE_01] Candidates: in use, type 001B to 101B, ready bit set.
// [RULE_02] Unmasked class first, then masks 1 to 4; never fall back.
// [RULE_03] Store only if new-data clear, or set with overwrite-select.
// [RULE_04] New-data set at start and end; update-in-progress held meanwhile.
// [RULE_05] History updated just before storage; ready locked during storage.
// [RULE_06] CPU buffer access may delay storage without corruption.
// [RULE_07] Twenty-three entry history with visible write and read pointers.
// [RULE_08] History contents undefined after leaving initialization mode.
// [RULE_09] Last-in register returns entry at write pointer minus one.
// [RULE_10] Each store writes buffer number at write pointer, then advances.
// [RULE_11] Get read returns oldest unread entry and advances read pointer.
// [RULE_12] Empty flag set when pointers match, cleared on new entry.
// [RULE_13] Overflow set when write pointer reaches read pointer minus one.
// [RULE_14] Under overflow write pointer frozen; newest entry overwritten.
// [RULE_15] Overflow sticky until software clear; empty not cleared meanwhile.
// [RULE_16] Each receive buffer links to one of four masks or none.
// [RULE_17] Mask bit one skips comparison; mask bit zero compares.
// [RULE_18] Type 010B: standard 11-bit identifier, linked to mask 1. Code: any type compares 11 or 29 bits, as frame_ext selects.
// [RULE_19] No match or blocked class: frame dropped, pointers unchanged.
`timescale 1ns/1ps
`default_nettype none
module crxb_rx_select
  import crxb_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic init_mode,
  input wire logic frame_valid,
  input wire logic [CRXB_IDW-1:0] frame_id,
  input wire logic frame_ext,
  input wire logic [CRXB_NBUF-1:0] buffer_in_use,
  input wire logic [3*CRXB_NBUF-1:0] buffer_type,
  input wire logic [CRXB_NBUF-1:0] overwrite_select,
  input wire logic [CRXB_IDW*CRXB_NBUF-1:0] buffer_id,
  input wire logic [CRXB_IDW*CRXB_NMASK-1:0] mask_id,
  input wire logic [CRXB_NBUF-1:0] cpu_buf_access,
  input wire logic [CRXB_NBUF-1:0] cpu_ready_set,
  input wire logic [CRXB_NBUF-1:0] cpu_ready_clr,
  input wire logic [CRXB_NBUF-1:0] cpu_dn_clr,
  input wire logic history_get_read,
  input wire logic history_ovf_clear,
  output logic [CRXB_NBUF-1:0] ready,
  output logic [CRXB_NBUF-1:0] new_data_flag,
  output logic [CRXB_NBUF-1:0] update_in_progress,
  output logic store_we,
  output logic [CRXB_BUFW-1:0] store_buf,
  output logic frame_dropped,
  output logic [CRXB_PTRW-1:0] history_write_pointer,
  output logic [CRXB_PTRW-1:0] history_read_pointer,
  output logic [CRXB_BUFW-1:0] last_in_register,
  output logic [CRXB_BUFW-1:0] history_get_register,
  output logic history_empty_flag,
  output logic history_overflow_flag
);
  // Class of a buffer: 0 unmasked .. 4 mask 4; 7 means not a receive buffer
  function automatic logic [2:0] buf_class(input logic [2:0] mt);
    if (mt >= CRXB_MT_RX_NOMASK && mt <= CRXB_MT_RX_MASK4) begin
      buf_class = mt - CRXB_MT_RX_NOMASK; // [RULE_16]
    end else begin
      buf_class = 3'h7;
    end
  endfunction : buf_class

  // Masked identifier compare; standard frames look at the top 11 bits
  function automatic logic id_match(input logic [CRXB_IDW-1:0] rx,
                                    input logic [CRXB_IDW-1:0] bid,
                                    input logic [CRXB_IDW-1:0] msk,
                                    input logic ext);
    logic [CRXB_IDW-1:0] diff;
    diff = (rx ^ bid) & ~msk; // [RULE_17]
    if (ext) begin
      id_match = (diff == '0);
    end else begin
      id_match = (diff[CRXB_IDW-1:CRXB_STD_LSB] == '0); // [RULE_18]
    end
  endfunction : id_match

  crxb_hist_if hif ();

  crxb_state_t state_q;
  logic [CRXB_NBUF-1:0] rdy_q;
  logic [CRXB_NBUF-1:0] dn_q;
  logic [CRXB_NBUF-1:0] muc_q;
  logic [CRXB_IDW-1:0] id_q;
  logic ext_q;
  logic [CRXB_BUFW-1:0] sel_q;
  logic [1:0] cyc_q;
  logic drop_q;
  logic we_q;

  // Search result, combinational from the latched frame
  logic [CRXB_NBUF-1:0] cand;
  logic [CRXB_NCLASS-1:0] class_hit;
  logic [2:0] top_class;
  logic found;
  logic [CRXB_BUFW-1:0] pick;
  logic can_store;

  always_comb begin
    logic [2:0] c;
    logic [CRXB_IDW-1:0] m;
    c = 3'h0;
    m = '0;
    cand = '0;
    class_hit = '0;
    for (int i = 0; i < CRXB_NBUF; i++) begin
      c = buf_class(buffer_type[3*i +: 3]);
      m = (c == 3'h0 || c == 3'h7) ? '0 : mask_id[CRXB_IDW*(c-1) +: CRXB_IDW];
      if (buffer_in_use[i] && c != 3'h7 && rdy_q[i] && // [RULE_01]
          id_match(id_q, buffer_id[CRXB_IDW*i +: CRXB_IDW], m, ext_q)) begin
        cand[i] = 1'b1;
        class_hit[c] = 1'b1;
      end
    end
  end

  // Lowest class number only; lowest buffer number within it
  always_comb begin
    top_class = 3'h0;
    found = 1'b0;
    pick = '0;
    for (int k = CRXB_NCLASS - 1; k >= 0; k--) begin
      if (class_hit[k]) begin
        top_class = 3'(k); // [RULE_02]
        found = 1'b1;
      end
    end
    for (int i = CRXB_NBUF - 1; i >= 0; i--) begin
      if (cand[i] && buf_class(buffer_type[3*i +: 3]) == top_class) begin
        pick = CRXB_BUFW'(i);
      end
    end
  end

  // Overwrite check on the picked buffer only; no fall back
  assign can_store = found && (!dn_q[pick] || overwrite_select[pick]); // [RULE_03]

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      id_q <= '0;
      ext_q <= 1'b0;
    end else if (state_q == CRXB_S_IDLE && frame_valid) begin
      id_q <= frame_id;
      ext_q <= frame_ext;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= CRXB_S_IDLE;
      sel_q <= '0;
      cyc_q <= '0;
    end else if (init_mode) begin
      state_q <= CRXB_S_IDLE;
    end else begin
      case (state_q)
        CRXB_S_IDLE: begin
          if (frame_valid) begin
            state_q <= CRXB_S_SEL;
          end
        end
        CRXB_S_SEL: begin
          if (can_store) begin
            sel_q <= pick;
            cyc_q <= '0;
            state_q <= CRXB_S_STORE;
          end else begin
            state_q <= CRXB_S_IDLE; // [RULE_19]
          end
        end
        CRXB_S_STORE: begin
          // CPU contention stretches storage rather than racing it
          if (!cpu_buf_access[sel_q]) begin
            cyc_q <= cyc_q + 2'h1; // [RULE_06]
            if (cyc_q == CRXB_STORE_CYC) begin
              state_q <= CRXB_S_DONE;
            end
          end
        end
        CRXB_S_DONE: begin
          state_q <= CRXB_S_IDLE;
        end
        default: begin
          state_q <= CRXB_S_IDLE;
        end
      endcase
    end
  end

  // Record pulse precedes the first storage cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      drop_q <= 1'b0;
    end else begin
      drop_q <= (state_q == CRXB_S_SEL) && !can_store && !init_mode;
    end
  end

  assign hif.rec = (state_q == CRXB_S_SEL) && can_store && !init_mode; // [RULE_05]
  assign hif.rec_buf = pick;
  // Get acts at once: the entry shown this cycle is the one consumed
  assign hif.get = history_get_read;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      muc_q <= '0;
    end else if (state_q == CRXB_S_SEL && can_store && !init_mode) begin
      muc_q[pick] <= 1'b1; // [RULE_04]
    end else if (state_q == CRXB_S_DONE || init_mode) begin
      muc_q <= '0;
    end
  end

  // Hardware set wins over the CPU clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dn_q <= '0;
    end else begin
      for (int i = 0; i < CRXB_NBUF; i++) begin
        if (state_q == CRXB_S_SEL && can_store && !init_mode && pick == i) begin
          dn_q[i] <= 1'b1; // [RULE_04]
        end else if (state_q == CRXB_S_DONE && sel_q == i) begin
          dn_q[i] <= 1'b1; // [RULE_04]
        end else if (cpu_dn_clr[i]) begin
          dn_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdy_q <= '0;
    end else begin
      for (int i = 0; i < CRXB_NBUF; i++) begin
        if (!muc_q[i]) begin // [RULE_05]
          if (cpu_ready_set[i] && !cpu_ready_clr[i]) begin
            rdy_q[i] <= 1'b1;
          end else if (cpu_ready_clr[i] && !cpu_ready_set[i]) begin
            rdy_q[i] <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      we_q <= 1'b0;
    end else begin
      we_q <= (state_q == CRXB_S_STORE) && !cpu_buf_access[sel_q] &&
              !init_mode; // [RULE_06]
    end
  end

  crxb_history u_hist (
    .clk(clk),
    .rstn(rstn),
    .hist_clear(init_mode),
    .hif(hif.hist),
    .ovf_clear(history_ovf_clear),
    .history_write_pointer(history_write_pointer),
    .history_read_pointer(history_read_pointer),
    .last_in_register(last_in_register),
    .history_get_register(history_get_register),
    .history_empty_flag(history_empty_flag),
    .history_overflow_flag(history_overflow_flag)
  );

  assign ready = rdy_q;
  assign new_data_flag = dn_q;
  assign update_in_progress = muc_q;
  assign store_we = we_q;
  assign store_buf = sel_q;
  assign frame_dropped = drop_q;

  sequence s_store_start;
    (state_q == CRXB_S_SEL) && can_store && !init_mode;
  endsequence

  property p_dn_start;
    @(posedge clk) disable iff (!rstn)
      s_store_start |=> (dn_q[sel_q] && muc_q[sel_q]);
  endproperty
  a_dn_start: assert property (p_dn_start) // [RULE_04]
    else $error("new-data or in-progress not set at store start");

  property p_muc_hold;
    @(posedge clk) disable iff (!rstn || init_mode)
      (state_q == CRXB_S_STORE) |-> muc_q[sel_q];
  endproperty
  a_muc_hold: assert property (p_muc_hold) // [RULE_04]
    else $error("in-progress dropped during storage");

  property p_rdy_lock;
    @(posedge clk) disable iff (!rstn)
      (muc_q != '0) |=> ((rdy_q & $past(muc_q)) == ($past(rdy_q) & $past(muc_q)));
  endproperty
  a_rdy_lock: assert property (p_rdy_lock) // [RULE_05]
    else $error("ready changed while locked");

  property p_drop_keeps_ptr;
    @(posedge clk) disable iff (!rstn || init_mode)
      ((state_q == CRXB_S_SEL) && !can_store) |=>
        $stable(history_write_pointer);
  endproperty
  a_drop_keeps_ptr: assert property (p_drop_keeps_ptr) // [RULE_19]
    else $error("write pointer moved on dropped frame");

  property p_pick_valid;
    @(posedge clk) disable iff (!rstn)
      s_store_start |-> (cand[pick] && buffer_in_use[pick] && rdy_q[pick]);
  endproperty
  a_pick_valid: assert property (p_pick_valid) // [RULE_01]
    else $error("stored into a non-candidate buffer");

  property p_no_fallback;
    @(posedge clk) disable iff (!rstn)
      s_store_start |-> (buf_class(buffer_type[3*pick +: 3]) == top_class);
  endproperty
  a_no_fallback: assert property (p_no_fallback) // [RULE_02]
    else $error("stored below the top class");

  property p_ows;
    @(posedge clk) disable iff (!rstn)
      s_store_start |-> (!dn_q[pick] || overwrite_select[pick]);
  endproperty
  a_ows: assert property (p_ows) // [RULE_03]
    else $error("overwrote protected buffer");

  property p_stall;
    @(posedge clk) disable iff (!rstn || init_mode)
      ((state_q == CRXB_S_STORE) && cpu_buf_access[sel_q]) |=>
        (!we_q && $stable(cyc_q));
  endproperty
  a_stall: assert property (p_stall) // [RULE_06]
    else $error("storage ran during CPU access");
endmodule : crxb_rx_select
`default_nettype wire

// File: src/crxb_pkg.sv
// Constants and types of the CAN receive buffer selection and history block.
// Assumes a single 20 MHz clock domain.
package crxb_pkg;
  localparam int CRXB_NBUF = 16;
  localparam int CRXB_BUFW = 4;
  localparam int CRXB_HIST_N = 23;
  localparam int CRXB_PTRW = 5;
  localparam int CRXB_IDW = 29;
  localparam int CRXB_NMASK = 4;
  localparam logic [CRXB_PTRW-1:0] CRXB_PTR_LAST = 5'h16;
  localparam logic [CRXB_PTRW-1:0] CRXB_PTR_ZERO = 5'h00;
  localparam logic [CRXB_PTRW-1:0] CRXB_PTR_ONE = 5'h01;
  // Buffer type codes
  localparam logic [2:0] CRXB_MT_TX = 3'h0;
  localparam logic [2:0] CRXB_MT_RX_NOMASK = 3'h1;
  localparam logic [2:0] CRXB_MT_RX_MASK1 = 3'h2;
  localparam logic [2:0] CRXB_MT_RX_MASK4 = 3'h5;
  // Standard identifier occupies the top 11 bits of the 29-bit field
  localparam int CRXB_STD_LSB = 18;
  // Storage cycles: three data copy cycles, counted 0 to 2
  localparam logic [1:0] CRXB_STORE_CYC = 2'h2;
  localparam int CRXB_NCLASS = 5;

  typedef enum logic [3:0] {
    CRXB_S_IDLE = 4'b0001,
    CRXB_S_SEL = 4'b0010,
    CRXB_S_STORE = 4'b0100,
    CRXB_S_DONE = 4'b1000
  } crxb_state_t;
endpackage : crxb_pkg

// File: src/crxb_hist_if.sv
// Carrier between the storage sequencer and the receive history list.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
interface crxb_hist_if;
  import crxb_pkg::*;
  logic rec;
  logic [CRXB_BUFW-1:0] rec_buf;
  logic get;
  modport seq (output rec, output rec_buf, output get);
  modport hist (input rec, input rec_buf, input get);
endinterface : crxb_hist_if
`default_nettype wire

// File: src/crxb_history.sv
// Receive history list: 23 buffer numbers, write and read pointers, flags.
// Assumes record and get requests are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module crxb_history
  import crxb_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic hist_clear,
  crxb_hist_if.hist hif,
  input wire logic ovf_clear,
  output logic [CRXB_PTRW-1:0] history_write_pointer,
  output logic [CRXB_PTRW-1:0] history_read_pointer,
  output logic [CRXB_BUFW-1:0] last_in_register,
  output logic [CRXB_BUFW-1:0] history_get_register,
  output logic history_empty_flag,
  output logic history_overflow_flag
);
  function automatic logic [CRXB_PTRW-1:0] ptr_inc(
      input logic [CRXB_PTRW-1:0] p);
    ptr_inc = (p == CRXB_PTR_LAST) ? CRXB_PTR_ZERO : p + CRXB_PTR_ONE;
  endfunction : ptr_inc

  function automatic logic [CRXB_PTRW-1:0] ptr_dec(
      input logic [CRXB_PTRW-1:0] p);
    ptr_dec = (p == CRXB_PTR_ZERO) ? CRXB_PTR_LAST : p - CRXB_PTR_ONE;
  endfunction : ptr_dec

  // Entries are not reset: contents are undefined after leaving init [RULE_08]
  logic [CRXB_BUFW-1:0] list_q [CRXB_HIST_N];
  logic [CRXB_PTRW-1:0] wp_q;
  logic [CRXB_PTRW-1:0] rp_q;
  logic empty_q;
  logic ovf_q;
  logic [CRXB_PTRW-1:0] wp_inc;
  logic [CRXB_PTRW-1:0] wr_idx;
  logic do_get;

  assign wp_inc = ptr_inc(wp_q);
  // Frozen pointer under overflow: overwrite the newest entry [RULE_14]
  assign wr_idx = ovf_q ? ptr_dec(wp_q) : wp_q;
  assign do_get = hif.get && !empty_q;

  always_ff @(posedge clk) begin
    if (hif.rec) begin
      list_q[wr_idx] <= hif.rec_buf; // [RULE_10]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_q <= CRXB_PTR_ZERO;
    end else if (hist_clear) begin
      wp_q <= CRXB_PTR_ZERO;
    end else if (hif.rec && !ovf_q) begin
      wp_q <= wp_inc; // [RULE_10] [RULE_14]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rp_q <= CRXB_PTR_ZERO;
    end else if (hist_clear) begin
      rp_q <= CRXB_PTR_ZERO;
    end else if (do_get) begin
      rp_q <= ptr_inc(rp_q); // [RULE_11]
    end
  end

  // Set on a fresh record wins over the software clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ovf_q <= 1'b0;
    end else if (hist_clear) begin
      ovf_q <= 1'b0;
    end else if (hif.rec && !ovf_q && wp_inc == ptr_dec(rp_q)) begin
      ovf_q <= 1'b1; // [RULE_13]
    end else if (ovf_clear) begin
      ovf_q <= 1'b0; // [RULE_15]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      empty_q <= 1'b1;
    end else if (hist_clear) begin
      empty_q <= 1'b1;
    end else if (hif.rec && !ovf_q) begin
      empty_q <= (wp_inc == (do_get ? ptr_inc(rp_q) : rp_q)); // [RULE_12]
    end else if (do_get) begin
      empty_q <= (ptr_inc(rp_q) == wp_q); // [RULE_12] [RULE_15]
    end
  end

  assign history_write_pointer = wp_q; // [RULE_07]
  assign history_read_pointer = rp_q;
  assign last_in_register = list_q[ptr_dec(wp_q)]; // [RULE_09]
  assign history_get_register = list_q[rp_q]; // [RULE_11]
  assign history_empty_flag = empty_q;
  assign history_overflow_flag = ovf_q;

  property p_ovf_freeze;
    @(posedge clk) disable iff (!rstn)
      (ovf_q && !hist_clear) |=> $stable(wp_q);
  endproperty
  a_ovf_freeze: assert property (p_ovf_freeze) // [RULE_14]
    else $error("write pointer moved under overflow");

  property p_ovf_sticky;
    @(posedge clk) disable iff (!rstn)
      (ovf_q && !ovf_clear && !hist_clear) |=> ovf_q;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) // [RULE_15]
    else $error("overflow dropped without clear");

  property p_ovf_set;
    @(posedge clk) disable iff (!rstn)
      (hif.rec && !ovf_q && !hist_clear && wp_inc == ptr_dec(rp_q))
        |=> ovf_q;
  endproperty
  a_ovf_set: assert property (p_ovf_set) // [RULE_13]
    else $error("overflow not set when list filled");

  property p_empty_match;
    @(posedge clk) disable iff (!rstn)
      (!ovf_q) |-> (empty_q == (wp_q == rp_q));
  endproperty
  a_empty_match: assert property (p_empty_match) // [RULE_12]
    else $error("empty flag disagrees with pointers");

  property p_rec_advance;
    @(posedge clk) disable iff (!rstn)
      (hif.rec && !ovf_q && !hist_clear) |=> (wp_q == ptr_inc($past(wp_q)));
  endproperty
  a_rec_advance: assert property (p_rec_advance) // [RULE_10]
    else $error("write pointer did not advance");

  property p_get_advance;
    @(posedge clk) disable iff (!rstn)
      (do_get && !hist_clear) |=> (rp_q == ptr_inc($past(rp_q)));
  endproperty
  a_get_advance: assert property (p_get_advance) // [RULE_11]
    else $error("read pointer did not advance");

  property p_last_in;
    @(posedge clk) disable iff (!rstn)
      (hif.rec && !ovf_q && !hist_clear)
        |=> (last_in_register == $past(hif.rec_buf));
  endproperty
  a_last_in: assert property (p_last_in) // [RULE_09]
    else $error("last-in entry not the newest record");
endmodule : crxb_history
`default_nettype wire

// File: verification/crxb_engine_model.sv
// Protocol engine stand-in: hands received frames over as one-cycle pulses.
// Assumes the bench requests a frame with a one-cycle send strobe.
`timescale 1ns/1ps
`default_nettype none
module crxb_engine_model
  import crxb_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic send,
  input wire logic [CRXB_IDW-1:0] send_id,
  input wire logic send_ext,
  output logic frame_valid,
  output logic [CRXB_IDW-1:0] frame_id,
  output logic frame_ext
);
  // Identifier churns between frames so nothing leans on a stale value
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frame_valid <= 1'b0;
      frame_id <= '0;
      frame_ext <= 1'b0;
    end else begin
      frame_valid <= send;
      frame_id <= send ? send_id : ~frame_id;
      frame_ext <= send ? send_ext : ~frame_ext;
    end
  end
endmodule : crxb_engine_model
`default_nettype wire

// File: verification/test_crxb_rx_select.sv
// Self-checking bench of the receive selection and history block.
// Assumes the engine model on the frame side; CPU side driven here.
`timescale 1ns/1ps
`default_nettype none
module test_crxb_rx_select;
  logic clk = 0, rstn = 0, init_mode = 0, send = 0, send_ext = 0;
  logic [28:0] send_id = '0;
  logic [15:0] buffer_in_use = '0, overwrite_select = '0;
  logic [15:0] cpu_buf_access = '0, cpu_ready_set = '0;
  logic [15:0] cpu_ready_clr = '0, cpu_dn_clr = '0;
  logic [47:0] buffer_type = '0;
  logic [463:0] buffer_id = '0;
  logic [115:0] mask_id = '0;
  logic history_get_read = 0, history_ovf_clear = 0;
  logic frame_valid, frame_ext, store_we, frame_dropped;
  logic [28:0] frame_id;
  logic [15:0] ready, new_data_flag, update_in_progress;
  logic [3:0] store_buf, last_in_register, history_get_register;
  logic [4:0] history_write_pointer, history_read_pointer;
  logic history_empty_flag, history_overflow_flag;
  int err_count = 0, samples_checked = 0, cyc = 0, exp_wp = 0, exp_rp = 0;
  int we_seen = 0;
  logic exp_ovf = 0, exp_empty = 1;

  crxb_engine_model crxb_engine_model_i (.clk, .rstn, .send, .send_id,
    .send_ext, .frame_valid, .frame_id, .frame_ext);
  crxb_rx_select crxb_rx_select_i (.clk, .rstn, .init_mode, .frame_valid,
    .frame_id, .frame_ext, .buffer_in_use, .buffer_type, .overwrite_select,
    .buffer_id, .mask_id, .cpu_buf_access, .cpu_ready_set, .cpu_ready_clr,
    .cpu_dn_clr, .history_get_read, .history_ovf_clear, .ready,
    .new_data_flag, .update_in_progress, .store_we, .store_buf,
    .frame_dropped, .history_write_pointer, .history_read_pointer,
    .last_in_register, .history_get_register, .history_empty_flag,
    .history_overflow_flag);

  always #25 clk = ~clk;

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  // Run is about five hundred cycles; five thousand means a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      results();
    end
  end

  // Copy cycles seen on the store strobe, for the per-frame count
  always @(posedge clk) begin
    if (store_we === 1'b1) we_seen++;
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask : tk

  task automatic cfg(input int b, input logic [2:0] t, input logic [28:0] id,
                     input logic ow);
    @(posedge clk);
    buffer_in_use[b] <= 1'b1;
    buffer_type[3*b +: 3] <= t;
    buffer_id[29*b +: 29] <= id;
    overwrite_select[b] <= ow;
    cpu_ready_set[b] <= 1'b1;
    @(posedge clk);
    cpu_ready_set <= '0;
  endtask : cfg

  // b below zero means the frame must be discarded
  task automatic frame(input logic [28:0] id, input logic ext, input int b,
                       input bit stall);
    int n;
    int w;
    @(posedge clk);
    send <= 1'b1;
    send_id <= id;
    send_ext <= ext;
    @(posedge clk);
    send <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (update_in_progress === '0 && frame_dropped !== 1'b1 && n < 12);
    if (b < 0) begin
      chk("dropped", frame_dropped, 1);
      chk("in progress", update_in_progress, 0);
    end else begin
      w = we_seen;
      chk("not dropped", frame_dropped, 0);
      if (!exp_ovf) begin
        exp_empty = 0;
        exp_wp = (exp_wp + 1) % 23;
        exp_ovf = (exp_wp == (exp_rp + 22) % 23);
      end
      chk("in progress", update_in_progress, 32'h1 << b);
      chk("new data start", new_data_flag[b], 1);
      chk("store_buf", store_buf, b);
      chk("wptr early", history_write_pointer, exp_wp);
      @(posedge clk);
      cpu_ready_clr[b] <= 1'b1;
      cpu_dn_clr[b] <= 1'b1;
      cpu_buf_access[b] <= stall;
      @(posedge clk);
      cpu_ready_clr <= '0;
      cpu_dn_clr <= '0;
      if (stall) begin
        tk(6);
        #1;
        chk("stalled", update_in_progress[b], 1);
        @(posedge clk);
        cpu_buf_access <= '0;
      end
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (update_in_progress !== '0 && n < 12);
      chk("copy cycles", we_seen - w, 3);
      chk("ready locked", ready[b], 1);
      chk("new data end", new_data_flag[b], 1);
      chk("last in", last_in_register, b);
    end
    chk("wptr", history_write_pointer, exp_wp);
    chk("rptr", history_read_pointer, exp_rp);
    chk("empty", history_empty_flag, exp_empty);
    chk("overflow", history_overflow_flag, exp_ovf);
    tk(3);
  endtask : frame

  task automatic get(input int b);
    @(posedge clk);
    history_get_read <= 1'b1;
    #1;
    chk("get entry", history_get_register, b);
    @(posedge clk);
    history_get_read <= 1'b0;
    exp_rp = (exp_rp + 1) % 23;
    exp_empty = (exp_rp == exp_wp);
    #1;
    chk("rptr after get", history_read_pointer, exp_rp);
    chk("empty after get", history_empty_flag, exp_empty);
  endtask : get

  task automatic t_basic();
    chk("wptr reset", history_write_pointer, 0);
    chk("empty reset", history_empty_flag, 1);
    cfg(3, 3'h1, 29'h0ABC_1234, 1'b0);
    frame(29'h0ABC_1234, 1'b1, 3, 0);
    get(3);
  endtask : t_basic

  // Unmasked outranks mask 1; a blocked top class never falls back
  task automatic t_prio();
    @(posedge clk);
    buffer_in_use <= '0;
    cfg(5, 3'h1, 29'h0000_0555, 1'b0);
    cfg(2, 3'h2, 29'h0000_0555, 1'b0);
    frame(29'h0000_0555, 1'b1, 5, 0);
    frame(29'h0000_0555, 1'b1, -1, 0);
    @(posedge clk);
    overwrite_select[5] <= 1'b1;
    frame(29'h0000_0555, 1'b1, 5, 0);
  endtask : t_prio

  // Type codes 000B to 101B on one buffer, each mask skipping ID28 only
  task automatic t_classes();
    @(posedge clk);
    buffer_in_use <= '0;
    for (int t = 0; t < 6; t++) begin
      // Only the linked mask skips ID28, so a wrong link drops the frame
      mask_id <= (t > 1) ? (116'h1 << (29 * (t - 2) + 28)) : '0;
      cfg(10, t[2:0], 29'h0123_4567, 1'b1);
      frame(29'h1123_4567, 1'b1, (t > 1) ? 10 : -1, 0);
    end
    @(posedge clk);
    cpu_ready_clr[10] <= 1'b1;
    @(posedge clk);
    cpu_ready_clr <= '0;
    frame(29'h0123_4567, 1'b1, -1, 0);
  endtask : t_classes

  task automatic t_mask();
    @(posedge clk);
    buffer_in_use <= '0;
    mask_id <= {87'h0, 29'h10BF_FFFF};
    cfg(9, 3'h2, 29'h0140_0000, 1'b1);
    frame(29'h11FF_FFFF, 1'b0, 9, 0);
    frame(29'h0540_0000, 1'b0, -1, 0);
    @(posedge clk);
    mask_id <= '0;
    frame(29'h0143_FFFF, 1'b0, 9, 0);
    frame(29'h0140_0000, 1'b0, 9, 1);
  endtask : t_mask

  task automatic t_ovf();
    @(posedge clk);
    init_mode <= 1'b1;
    buffer_in_use <= '0;
    @(posedge clk);
    init_mode <= 1'b0;
    exp_wp = 0;
    exp_rp = 0;
    exp_ovf = 0;
    exp_empty = 1;
    cfg(4, 3'h1, 29'h0000_0044, 1'b1);
    cfg(7, 3'h1, 29'h0000_0077, 1'b1);
    repeat (22) frame(29'h0000_0044, 1'b1, 4, 0);
    frame(29'h0000_0077, 1'b1, 7, 0);
    for (int i = 0; i < 22; i++) get((i == 21) ? 7 : 4);
    frame(29'h0000_0044, 1'b1, 4, 0);
    @(posedge clk);
    history_ovf_clear <= 1'b1;
    @(posedge clk);
    history_ovf_clear <= 1'b0;
    #1;
    chk("overflow cleared", history_overflow_flag, 0);
  endtask : t_ovf

  initial begin
    tk(8);
    rstn <= 1'b1;
    #1;
    t_basic();
    t_prio();
    t_classes();
    t_mask();
    t_ovf();
    results();
  end
endmodule : test_crxb_rx_select
`default_nettype wire
